//--- rtl/hbsd_pkg.sv
/*
 Constants for the H-bridge state decoder: fault codes, drive states,
 loss-of-toggle timing.
 Assumes a 50 MHz system clock.
*/
package hbsd_pkg;
   // Fault code values {bit1,bit0}
   localparam logic [1:0] CODE_ILLEGAL  = 2'h0;
   localparam logic [1:0] CODE_SHORT    = 2'h1;
   localparam logic [1:0] CODE_OVERTEMP = 2'h2;
   localparam logic [1:0] CODE_LOWVOLT  = 2'h3;
   localparam logic [1:0] CODE_WARN     = 2'h2;
   localparam logic [1:0] CODE_NORMAL   = 2'h3;
   // Clock and loss-of-toggle window
   localparam int CLK_HZ          = 50000000;
   localparam int TOGGLE_LOSS_US  = 50;
   localparam int TOGGLE_LOSS_CYC = (TOGGLE_LOSS_US * (CLK_HZ / 1000000));
   localparam int TOGGLE_CNT_W    = 12;
   // Reset values
   localparam logic       SHORT_LATCH_RST = 1'b0;
   localparam logic [1:0] STATE_RST       = 2'h0;
   // Output state selection
   typedef enum logic [1:0] {
      HBSD_PWRDN  = 2'h0,
      HBSD_MUTE   = 2'h1,
      HBSD_RUN    = 2'h3,
      HBSD_FAULT  = 2'h2
   } hbsd_mode_t;
endpackage

//--- rtl/hbsd_top.sv
/*
 H-bridge state decoder: two complementary PWM pairs to two bridge drives,
 with power-down, reset/mute, fault detection and open-drain status flags.
 Assumes PWM and analog fault inputs are synchronous to clk.
*/
`timescale 1ns/100ps
module hbsd_top (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic power_down_n,
   input  wire logic reset_in_n,
   input  wire logic side_a_pos_in,
   input  wire logic side_a_neg_in,
   input  wire logic side_b_pos_in,
   input  wire logic side_b_neg_in,
   input  wire logic over_current,
   input  wire logic over_temp,
   input  wire logic low_voltage,
   input  wire logic temp_warning,
   output logic      bridge_a_drive,
   output logic      bridge_a_drive_oe,
   output logic      bridge_b_drive,
   output logic      bridge_b_drive_oe,
   output logic      shutdown_n_out,
   output logic      shutdown_n_oe,
   output logic      fault_code_bit0,
   output logic      fault_code_bit0_oe,
   output logic      fault_code_bit1,
   output logic      fault_code_bit1_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Pair decoding
   ////////////////////////////////////////////////////////////////////////
   // Equal levels on a complementary pair are never a valid command
   function automatic logic pair_illegal(input logic p, input logic n);
      return (p == n);
   endfunction

   // Idle counter step: restart on an edge or outside run, stop at the limit
   function automatic logic [hbsd_pkg::TOGGLE_CNT_W-1:0] idle_step(
      input logic                              restart,
      input logic                              at_limit,
      input logic [hbsd_pkg::TOGGLE_CNT_W-1:0] count
   );
      if (restart)
         return '0;
      if (at_limit)
         return count;
      return count + 1'b1;
   endfunction

   logic                                  prev_a_pos;
   logic                                  prev_b_pos;
   logic [hbsd_pkg::TOGGLE_CNT_W-1:0]     idle_a;
   logic [hbsd_pkg::TOGGLE_CNT_W-1:0]     idle_b;
   logic [hbsd_pkg::TOGGLE_CNT_W-1:0]     next_idle_a;
   logic [hbsd_pkg::TOGGLE_CNT_W-1:0]     next_idle_b;
   logic                                  short_latch;
   logic                                  short_hold;
   logic                                  short_now;
   logic                                  edge_a;
   logic                                  edge_b;
   logic                                  stall_a;
   logic                                  stall_b;
   logic                                  illegal_a;
   logic                                  illegal_b;
   logic                                  illegal;
   logic                                  sensed;
   logic                                  fault;
   logic [1:0]                            fault_code;
   logic                                  run;
   hbsd_pkg::hbsd_mode_t                  mode;

   localparam logic [hbsd_pkg::TOGGLE_CNT_W-1:0] IDLE_MAX =
      hbsd_pkg::TOGGLE_CNT_W'(hbsd_pkg::TOGGLE_LOSS_CYC);

   // Toggle watch per side
   assign edge_a      = side_a_pos_in != prev_a_pos;
   assign edge_b      = side_b_pos_in != prev_b_pos;
   assign stall_a     = idle_a == IDLE_MAX;
   assign stall_b     = idle_b == IDLE_MAX;
   assign next_idle_a = idle_step(edge_a | !run, stall_a, idle_a);
   assign next_idle_b = idle_step(edge_b | !run, stall_b, idle_b);

   // Same decode per side, either side can raise the illegal state
   assign run       = power_down_n & reset_in_n;
   assign illegal_a = pair_illegal(side_a_pos_in, side_a_neg_in) | stall_a;
   assign illegal_b = pair_illegal(side_b_pos_in, side_b_neg_in) | stall_b;
   assign illegal   = illegal_a | illegal_b;

   // Reset low masks the latch at once, so mute never shows a stale short
   assign short_hold = short_latch & reset_in_n;
   assign short_now  = short_hold | (run & over_current);

   // Self-clearing faults, only meaningful while running
   assign sensed = over_temp | low_voltage | illegal;
   assign fault  = short_now | (run & sensed);

   // Fault code priority: short, low voltage, over-temp, illegal
   assign fault_code = short_now   ? hbsd_pkg::CODE_SHORT    :
                       low_voltage ? hbsd_pkg::CODE_LOWVOLT  :
                       over_temp   ? hbsd_pkg::CODE_OVERTEMP :
                                     hbsd_pkg::CODE_ILLEGAL;

   // Mode selection
   assign mode = fault         ? hbsd_pkg::HBSD_FAULT :
                 !power_down_n ? hbsd_pkg::HBSD_PWRDN :
                 !reset_in_n   ? hbsd_pkg::HBSD_MUTE  :
                                 hbsd_pkg::HBSD_RUN;

   ////////////////////////////////////////////////////////////////////////
   // Toggle counters and short-circuit latch
   ////////////////////////////////////////////////////////////////////////
   // Last positive level per side, for edge detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_a_pos <= 1'b0;
         prev_b_pos <= 1'b0;
      end else begin
         prev_a_pos <= side_a_pos_in;
         prev_b_pos <= side_b_pos_in;
      end
   end

   // Idle counters, restarted whenever power_down_n or reset_in_n is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_a <= '0;
         idle_b <= '0;
      end else begin
         idle_a <= next_idle_a;
         idle_b <= next_idle_b;
      end
   end

   // Over-current latch, cleared only by reset low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         short_latch <= hbsd_pkg::SHORT_LATCH_RST;
      end else if (!reset_in_n) begin
         short_latch <= 1'b0;
      end else if (power_down_n & over_current) begin
         short_latch <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next output values
   ////////////////////////////////////////////////////////////////////////
   logic                                  in_fault;
   logic                                  in_pwrdn;
   logic                                  in_run;
   logic                                  short_shown;
   logic                                  next_a_drive;
   logic                                  next_a_oe;
   logic                                  next_b_drive;
   logic                                  next_b_oe;
   logic                                  next_sd_oe;
   logic                                  next_c0_oe;
   logic                                  next_c1_oe;

   // Decoded view of the selected mode
   assign in_fault    = mode == hbsd_pkg::HBSD_FAULT;
   assign in_pwrdn    = mode == hbsd_pkg::HBSD_PWRDN;
   assign in_run      = mode == hbsd_pkg::HBSD_RUN;

   // Over-current floats the bridges, other faults hold them low
   assign short_shown = in_fault & (fault_code == hbsd_pkg::CODE_SHORT);

   // Bridges: floating in power-down and short, low in mute and other faults
   assign next_a_oe    = !in_pwrdn & !short_shown;
   assign next_b_oe    = !in_pwrdn & !short_shown;
   assign next_a_drive = in_run & side_a_pos_in;
   assign next_b_drive = in_run & side_b_pos_in;

   // Status pull-downs; all released outside fault and run
   assign next_sd_oe = in_fault;
   assign next_c0_oe = in_fault ? !fault_code[0] : (in_run & temp_warning);
   assign next_c1_oe = in_fault & !fault_code[1];

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   ////////////////////////////////////////////////////////////////////////
   // Bridge A drive and enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bridge_a_drive    <= 1'b0;
         bridge_a_drive_oe <= 1'b0;
      end else begin
         bridge_a_drive    <= next_a_drive;
         bridge_a_drive_oe <= next_a_oe;
      end
   end

   // Bridge B drive and enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bridge_b_drive    <= 1'b0;
         bridge_b_drive_oe <= 1'b0;
      end else begin
         bridge_b_drive    <= next_b_drive;
         bridge_b_drive_oe <= next_b_oe;
      end
   end

   // Shutdown pull-down
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shutdown_n_oe <= 1'b0;
      end else begin
         shutdown_n_oe <= next_sd_oe;
      end
   end

   // Fault code pull-downs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_code_bit0_oe <= 1'b0;
         fault_code_bit1_oe <= 1'b0;
      end else begin
         fault_code_bit0_oe <= next_c0_oe;
         fault_code_bit1_oe <= next_c1_oe;
      end
   end

   // Open-drain values: always low, the enable decides whether the pin is pulled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shutdown_n_out  <= 1'b0;
         fault_code_bit0 <= 1'b0;
         fault_code_bit1 <= 1'b0;
      end else begin
         shutdown_n_out  <= 1'b0;
         fault_code_bit0 <= 1'b0;
         fault_code_bit1 <= 1'b0;
      end
   end
endmodule

//--- tb/hbsd_assertions.sv
/* Port checker for hbsd_top.
 Assumes binding onto hbsd_top, one clock. */
`timescale 1ns/100ps
module hbsd_assertions (
   input wire logic clk, rst_n, power_down_n, reset_in_n, over_current, over_temp,
   input wire logic low_voltage, temp_warning, side_a_pos_in, side_a_neg_in,
   input wire logic side_b_pos_in, side_b_neg_in, bridge_a_drive, bridge_a_drive_oe,
   input wire logic bridge_b_drive, bridge_b_drive_oe, shutdown_n_out, shutdown_n_oe,
   input wire logic fault_code_bit0, fault_code_bit0_oe, fault_code_bit1, fault_code_bit1_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Decoded conditions
   wire run = power_down_n && reset_in_n;
   wire bad = (side_a_pos_in == side_a_neg_in) || (side_b_pos_in == side_b_neg_in);
   wire lows = bridge_a_drive_oe && !bridge_a_drive && bridge_b_drive_oe && !bridge_b_drive;
   wire short_st = shutdown_n_oe && fault_code_bit1_oe && !fault_code_bit0_oe;
   // Mirror of the loss-of-toggle window per side
   localparam logic [11:0] QMAX = 12'(hbsd_pkg::TOGGLE_LOSS_CYC);
   logic [11:0] quiet_a, quiet_b;
   logic        last_a, last_b;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_a <= 12'h0;
         quiet_b <= 12'h0;
         last_a  <= 1'b0;
         last_b  <= 1'b0;
      end else begin
         last_a  <= side_a_pos_in;
         last_b  <= side_b_pos_in;
         quiet_a <= (side_a_pos_in != last_a || !run) ? 12'h0 :
                    (quiet_a == QMAX) ? quiet_a : quiet_a + 12'h1;
         quiet_b <= (side_b_pos_in != last_b || !run) ? 12'h0 :
                    (quiet_b == QMAX) ? quiet_b : quiet_b + 12'h1;
      end
   end
   wire stall = (quiet_a == QMAX) || (quiet_b == QMAX);
   sequence s_short; short_st && !bridge_a_drive_oe && !bridge_b_drive_oe; endsequence
   sequence s_mute; lows && !shutdown_n_oe; endsequence
   chk_pins_low: assert property (!shutdown_n_out && !fault_code_bit0 && !fault_code_bit1)
      else $error("status pin driven high");
   chk_pwrdn_hiz: assert property ($past(rst_n && !power_down_n) |->
      !bridge_a_drive_oe && !bridge_b_drive_oe) else $error("bridge driven in power-down");
   chk_mute_low: assert property ($past(rst_n && power_down_n && !reset_in_n) |-> s_mute)
      else $error("mute state wrong");
   chk_run_decode: assert property ($past(rst_n && run && !bad && !stall
      && !low_voltage && !over_temp && !over_current) && !short_st |-> !shutdown_n_oe
      && bridge_a_drive == $past(side_a_pos_in) && bridge_b_drive == $past(side_b_pos_in)
      && bridge_a_drive_oe && bridge_b_drive_oe && !fault_code_bit1_oe
      && fault_code_bit0_oe == $past(temp_warning)) else $error("decode wrong");
   chk_illegal_low: assert property ($past(rst_n && run && bad && !low_voltage
      && !over_temp) && !short_st
      |-> shutdown_n_oe && fault_code_bit1_oe && fault_code_bit0_oe && lows)
      else $error("illegal input not shut down");
   chk_stall_shut: assert property ($past(rst_n && run && stall && !low_voltage
      && !over_temp) && !short_st
      |-> shutdown_n_oe && fault_code_bit1_oe && fault_code_bit0_oe && lows)
      else $error("toggle loss not shut down");
   chk_lowvolt_code: assert property ($past(rst_n && run && low_voltage) && !short_st |->
      shutdown_n_oe && !fault_code_bit1_oe && !fault_code_bit0_oe && lows) else $error("low volt");
   chk_hot_code: assert property ($past(rst_n && run && over_temp && !low_voltage)
      && !short_st |-> shutdown_n_oe && !fault_code_bit1_oe && fault_code_bit0_oe && lows)
      else $error("over temp");
   chk_short_set: assert property ($past(rst_n && run && over_current) |-> s_short)
      else $error("short not latched");
   chk_short_hold: assert property (s_short ##0 run |=> s_short)
      else $error("short latch lost");
endmodule
bind hbsd_top hbsd_assertions i_chk (.*);

//--- tb/hbsd_modulator.sv
/* Modulator model for the two PWM pairs.
 Assumes clk is the decoder clock. */
`timescale 1ns/100ps
module hbsd_modulator (
   input  wire logic       clk,
   input  wire logic [1:0] bad,
   input  wire logic       hold,
   output logic            pos_a,
   output logic            neg_a,
   output logic            pos_b,
   output logic            neg_b
);
   logic [1:0] r;
   initial {pos_a, neg_a, pos_b, neg_b} = 4'h5;
   // Fresh random level each cycle while hold is low, all four always driven
   always @(posedge clk) begin
      r = hold ? {pos_b, pos_a} : 2'($urandom); // Hold freezes the positive levels
      #1;
      {pos_a, neg_a} <= {r[0], ~r[0] ^ bad[0]};
      {pos_b, neg_b} <= {r[1], ~r[1] ^ bad[1]};
   end
endmodule

//--- tb/tb_top.sv
/* Bench for hbsd_top with queued expectations.
 Assumes the checker binds itself. */
`timescale 1ns/100ps
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, power_down_n = 1'b1, reset_in_n = 1'b0, latch = 1'b0;
   logic over_current = 1'b0, over_temp = 1'b0, low_voltage = 1'b0, temp_warning = 1'b0;
   logic [1:0] bad = 2'h0;
   logic hold = 1'b0, stall = 1'b0, last_a = 1'b0, last_b = 1'b0;
   int quiet_a = 0, quiet_b = 0;
   logic side_a_pos_in, side_a_neg_in, side_b_pos_in, side_b_neg_in, shutdown_n_out;
   logic bridge_a_drive, bridge_a_drive_oe, bridge_b_drive, bridge_b_drive_oe, shutdown_n_oe;
   logic fault_code_bit0, fault_code_bit0_oe, fault_code_bit1, fault_code_bit1_oe;
   logic [7:0] exp_q[$];
   logic [7:0] tbl[16] = '{8'hc0, 8'hc4, 8'hc1, 8'hc2, 8'hc3, 8'hc8, 8'hd0, 8'hd8,
                           8'hc0, 8'hec, 8'hc0, 8'h80, 8'h00, 8'h58, 8'h98, 8'hc0};
   int n_errors = 0, cmp_count = 0;
   hbsd_top i_hbsd_top (.*);
   hbsd_modulator i_hbsd_modulator (.clk, .bad, .hold, .pos_a(side_a_pos_in), .neg_a(side_a_neg_in),
      .pos_b(side_b_pos_in), .neg_b(side_b_neg_in));
   ////////////////////////////////////////////////////////////////////////////////
   // Expected {mask, a_oe, a, b_oe, b, sd_oe, c1_oe, c0_oe}
   function automatic logic [7:0] expect_out();
      if (latch) return 8'h86;
      if (!power_down_n) return 8'h80;
      if (!reset_in_n) return 8'hd0;
      if (low_voltage) return 8'hd4;
      if (over_temp) return 8'hd5;
      if (side_a_pos_in == side_a_neg_in || side_b_pos_in == side_b_neg_in) return 8'hd7;
      if (stall) return 8'hd7;
      return {2'h3, side_a_pos_in, 1'b1, side_b_pos_in, 2'h0, temp_warning};
   endfunction
   task automatic step(input logic [7:0] v, input int n);
      repeat (n) begin
         @(posedge clk);
         #1 {power_down_n, reset_in_n, over_current, over_temp} = v[7:4];
         {low_voltage, temp_warning, bad} = v[3:0];
         #1 latch = reset_in_n && (latch || (power_down_n && over_current));
         stall = (quiet_a == hbsd_pkg::TOGGLE_LOSS_CYC) || (quiet_b == hbsd_pkg::TOGGLE_LOSS_CYC);
         exp_q.push_back(expect_out());
         // Count unchanged positive levels while running, saturating
         if (!(power_down_n && reset_in_n) || side_a_pos_in != last_a) quiet_a = 0;
         else if (quiet_a < hbsd_pkg::TOGGLE_LOSS_CYC) quiet_a++;
         if (!(power_down_n && reset_in_n) || side_b_pos_in != last_b) quiet_b = 0;
         else if (quiet_b < hbsd_pkg::TOGGLE_LOSS_CYC) quiet_b++;
         last_a = side_a_pos_in;
         last_b = side_b_pos_in;
      end
   endtask
   task automatic compare(input logic [7:0] e);
      logic [7:0] o;
      o = {e[7], bridge_a_drive_oe, bridge_a_drive_oe & bridge_a_drive, bridge_b_drive_oe,
           bridge_b_drive_oe & bridge_b_drive, shutdown_n_oe, fault_code_bit1_oe & e[7],
           fault_code_bit0_oe & e[7]};
      cmp_count++;
      if (o !== e) begin
         n_errors++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, o);
      end
   endtask
   task automatic print_verdict();
      $display("Compares %0d, errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Clock and result watcher
   initial forever #10 clk = ~clk;
   always @(posedge clk) begin
      #3;
      if (exp_q.size() > 1) compare(exp_q.pop_front());
   end
   // Directed table, then random modes
   initial begin
      int unsigned r;
      void'($urandom(23820));
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      foreach (tbl[i]) step(tbl[i], 3);
      repeat (400) begin
         r = $urandom;
         step({|r[9:8], |r[11:10], 1'b0, r[4:0]}, 1);
      end
      step(8'hc0, 2);
      hold = 1'b1;
      step(8'hc0, 2510);
      hold = 1'b0;
      step(8'hc0, 4);
      print_verdict();
   end
endmodule
